// >>> hdl/clkgen_pkg.sv
// Constants, types and register layout of the clock generator config port.
package clkgen_pkg;

   // ********************************************************************
   // Serial target and register layout
   // ********************************************************************
   localparam logic [6:0] TARGET_ADDR = 7'h6E;
   localparam int REG_COUNT = 24;
   localparam int SET_COUNT = 4;
   localparam int FB_BASE = 0;
   localparam int OD_BASE = 4;
   localparam int MODE_BASE = 8;
   localparam int OUT_BASE = 12;
   localparam int SKIP_BIT = 7;
   localparam int DRIVE_LSB = 0;
   localparam int STYLE_LSB = 4;
   localparam int OUT_COUNT = 4;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [7:0] FB_RESET = 8'h10;
   localparam logic [7:0] OD_RESET = 8'h08;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] OUT_RESET = 8'h0F;
   localparam logic [7:0] SPARE_RESET = 8'h00;

   // ********************************************************************
   // Bus register map
   // ********************************************************************
   localparam logic [31:0] CTRL_ADDR = 32'h0000_0000;
   localparam logic [31:0] STATUS_ADDR = 32'h0000_0004;
   localparam int EN_BIT = 0;
   localparam int BUSY_BIT = 0;
   localparam int WROTE_BIT = 1;
   localparam logic EN_RESET = 1'b1;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_ADDR = 3'h1,
      ST_ACK = 3'h3,
      ST_RX = 3'h2,
      ST_TX = 3'h6,
      ST_RACK = 3'h7
   } i2c_state_t;

   typedef struct packed {
      logic [7:0] feedback_div;
      logic [7:0] output_div;
      logic [7:0] pll_mode;
      logic pll_skip_bit;
      logic [OUT_COUNT-1:0] output_drive_bit;
      logic [OUT_COUNT-1:0] output_style_bit;
   } clock_config_t;

   function automatic logic [7:0] reg_reset(input int idx);
      if (idx < OD_BASE) return FB_RESET;
      if (idx < MODE_BASE) return OD_RESET;
      if (idx < OUT_BASE) return MODE_RESET;
      if (idx < OUT_BASE + SET_COUNT) return OUT_RESET;
      return SPARE_RESET;
   endfunction

endpackage

// >>> hdl/clock_gen_config_i2c_slave.sv
// Serial configuration target and set selection of a clock generator.
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module clock_gen_config_i2c_slave #(
   parameter int REGS = clkgen_pkg::REG_COUNT
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic link_clk,
   input wire logic scl_in,
   input wire logic serial_data_pin_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe_n,
   input wire logic [1:0] frequency_set_select,
   output clkgen_pkg::clock_config_t active_config
);

   localparam int IW = $clog2(REGS);

   if (REGS < clkgen_pkg::OUT_BASE + clkgen_pkg::SET_COUNT || REGS > 256)
   begin : g_check
      $error("REGS must hold all set bytes and fit an 8-bit pointer");
   end

   function automatic logic in_map(input logic [7:0] p);
      return int'(p) < REGS;
   endfunction

   // ********************************************************************
   // Link side synchronisers
   // ********************************************************************
   logic scl_m, scl_s, sda_m, sda_s, en_m, en_s, rst_m, link_resetn;
   logic [1:0] fsel_m, fsel_s, fsel_t;
   logic port_enable;

   // Pins are sampled on the fast link clock, so every edge is seen late by
   // two cycles; the bus rate must stay well below the link clock rate.
   always_ff @(posedge link_clk) begin
      scl_m <= scl_in;
      scl_s <= scl_m;
      sda_m <= serial_data_pin_in;
      sda_s <= sda_m;
      fsel_m <= frequency_set_select;
      fsel_s <= fsel_m;
      fsel_t <= fsel_s;
      en_m <= port_enable;
      en_s <= en_m;
      rst_m <= aresetn;
      link_resetn <= rst_m;
   end

   // ********************************************************************
   // Serial target engine
   // ********************************************************************
   clkgen_pkg::i2c_state_t state, next_state;
   logic scl_q, sda_q;
   logic [3:0] bitcnt, next_bitcnt;
   logic [7:0] shreg, next_shreg, ptr, next_ptr;
   logic first_rx, next_first_rx, rd_mode, next_rd_mode;
   logic oe_n, next_oe_n, wr_tog, next_wr_tog;
   logic [7:0] regs [REGS];
   logic [7:0] next_regs [REGS];
   clkgen_pkg::clock_config_t cfg, next_cfg;
   logic scl_rise, scl_fall, start, stop, addr_hit;
   logic [7:0] rd_byte;

   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign start = scl_s & scl_q & sda_q & ~sda_s;
   assign stop = scl_s & scl_q & ~sda_q & sda_s;
   assign addr_hit = (shreg[7:1] == clkgen_pkg::TARGET_ADDR) && en_s;
   assign rd_byte = in_map(ptr) ? regs[ptr[IW-1:0]] : 8'h00;

   always_comb begin
      int s;
      s = int'(fsel_s);
      next_state = state;
      next_bitcnt = bitcnt;
      next_shreg = shreg;
      next_ptr = ptr;
      next_first_rx = first_rx;
      next_rd_mode = rd_mode;
      next_oe_n = oe_n;
      next_wr_tog = wr_tog;
      next_regs = regs;
      // Live selection: no latch on the set, so a register write shows one cycle
      // later and a pin change three cycles after the edge that first samples it.
      next_cfg.feedback_div = regs[clkgen_pkg::FB_BASE + s];
      next_cfg.output_div = regs[clkgen_pkg::OD_BASE + s];
      next_cfg.pll_mode = regs[clkgen_pkg::MODE_BASE + s];
      next_cfg.pll_skip_bit =
         regs[clkgen_pkg::MODE_BASE + s][clkgen_pkg::SKIP_BIT];
      next_cfg.output_drive_bit = regs[clkgen_pkg::OUT_BASE + s]
         [clkgen_pkg::DRIVE_LSB +: clkgen_pkg::OUT_COUNT];
      next_cfg.output_style_bit = regs[clkgen_pkg::OUT_BASE + s]
         [clkgen_pkg::STYLE_LSB +: clkgen_pkg::OUT_COUNT];
      // Both select bits must agree for two cycles, so that skew of less than one
      // link cycle between the pins never shows a set that was only passed through.
      if (fsel_s != fsel_t) next_cfg = cfg;
      if (start) begin
         next_state = clkgen_pkg::ST_ADDR;
         next_bitcnt = 4'h0;
         next_oe_n = 1'b1;
      end else if (stop) begin
         next_state = clkgen_pkg::ST_IDLE;
         next_oe_n = 1'b1;
      end else begin
         unique case (state)
            clkgen_pkg::ST_IDLE: begin
            end
            clkgen_pkg::ST_ADDR, clkgen_pkg::ST_RX: begin
               if (scl_rise) begin
                  next_shreg = {shreg[6:0], sda_s};
                  next_bitcnt = bitcnt + 4'h1;
               end else if (scl_fall && bitcnt == clkgen_pkg::BYTE_BITS)
               begin
                  if (state == clkgen_pkg::ST_ADDR) begin
                     if (addr_hit) begin
                        next_state = clkgen_pkg::ST_ACK;
                        next_oe_n = 1'b0;
                        next_rd_mode = shreg[0];
                        next_first_rx = ~shreg[0];
                     end else begin
                        next_state = clkgen_pkg::ST_IDLE;
                     end
                  end else begin
                     next_state = clkgen_pkg::ST_ACK;
                     next_oe_n = 1'b0;
                     if (first_rx) begin
                        next_ptr = shreg;
                        next_first_rx = 1'b0;
                     end else begin
                        // Bytes past the map are acked and dropped.
                        if (in_map(ptr)) begin
                           next_regs[ptr[IW-1:0]] = shreg;
                           next_wr_tog = ~wr_tog;
                        end
                        next_ptr = ptr + 8'h01;
                     end
                  end
               end
            end
            clkgen_pkg::ST_ACK, clkgen_pkg::ST_RACK: begin
               if (state == clkgen_pkg::ST_RACK && scl_rise && sda_s) begin
                  next_state = clkgen_pkg::ST_IDLE;
               end else if (scl_fall) begin
                  if (rd_mode) begin
                     next_state = clkgen_pkg::ST_TX;
                     next_shreg = rd_byte;
                     next_oe_n = rd_byte[7];
                     next_ptr = ptr + 8'h01;
                     next_bitcnt = 4'h1;
                  end else begin
                     next_state = clkgen_pkg::ST_RX;
                     next_oe_n = 1'b1;
                     next_bitcnt = 4'h0;
                  end
               end
            end
            clkgen_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (bitcnt == clkgen_pkg::BYTE_BITS) begin
                     next_state = clkgen_pkg::ST_RACK;
                     next_oe_n = 1'b1;
                  end else begin
                     next_shreg = {shreg[6:0], 1'b0};
                     next_oe_n = shreg[6];
                     next_bitcnt = bitcnt + 4'h1;
                  end
               end
            end
            default: begin
               next_state = clkgen_pkg::ST_IDLE;
               next_oe_n = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk) begin
      if (!link_resetn) begin
         state <= clkgen_pkg::ST_IDLE;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         ptr <= 8'h00;
         first_rx <= 1'b0;
         rd_mode <= 1'b0;
         oe_n <= 1'b1;
         wr_tog <= 1'b0;
         for (int i = 0; i < REGS; i++) begin
            regs[i] <= clkgen_pkg::reg_reset(i);
         end
         cfg <= '0;
      end else begin
         state <= next_state;
         scl_q <= scl_s;
         sda_q <= sda_s;
         bitcnt <= next_bitcnt;
         shreg <= next_shreg;
         ptr <= next_ptr;
         first_rx <= next_first_rx;
         rd_mode <= next_rd_mode;
         oe_n <= next_oe_n;
         wr_tog <= next_wr_tog;
         regs <= next_regs;
         cfg <= next_cfg;
      end
   end

   assign serial_data_pin_out = 1'b0;
   assign serial_data_pin_oe_n = oe_n;
   assign active_config = cfg;

   AST_FOREIGN_IGNORED: assert property (
      @(posedge link_clk) disable iff (!link_resetn)
      state == clkgen_pkg::ST_ADDR && scl_fall && bitcnt == 4'h8
      && !addr_hit |=> state == clkgen_pkg::ST_IDLE && oe_n)
      else $error("foreign address was not ignored");
   AST_OWN_ADDR_ACK: assert property (
      @(posedge link_clk) disable iff (!link_resetn)
      state == clkgen_pkg::ST_ADDR && scl_fall && bitcnt == 4'h8
      && addr_hit |=> state == clkgen_pkg::ST_ACK && !oe_n)
      else $error("own address was not acknowledged");
   AST_PTR_TAKEN: assert property (
      @(posedge link_clk) disable iff (!link_resetn)
      state == clkgen_pkg::ST_RX && first_rx && scl_fall
      && bitcnt == 4'h8 |=> ptr == $past(shreg) && !oe_n)
      else $error("pointer byte not loaded");
   AST_WRITE_STEP: assert property (
      @(posedge link_clk) disable iff (!link_resetn)
      state == clkgen_pkg::ST_RX && !first_rx && scl_fall
      && bitcnt == 4'h8 |=> ptr == $past(ptr) + 8'h01)
      else $error("pointer did not step after a data byte");
   AST_WRITE_STORE: assert property (
      @(posedge link_clk) disable iff (!link_resetn)
      state == clkgen_pkg::ST_RX && !first_rx && scl_fall
      && bitcnt == 4'h8 && in_map(ptr) |=> wr_tog != $past(wr_tog)
      && regs[$past(ptr[IW-1:0])] == $past(shreg))
      else $error("data byte not stored");
   AST_START_ADDR: assert property (
      @(posedge link_clk) disable iff (!link_resetn)
      start |=> state == clkgen_pkg::ST_ADDR && bitcnt == 4'h0 && oe_n)
      else $error("start did not open an address phase");
   AST_STOP_END: assert property (
      @(posedge link_clk) disable iff (!link_resetn)
      stop |=> state == clkgen_pkg::ST_IDLE ##1 oe_n)
      else $error("stop did not end the transfer");
   AST_TX_MSB: assert property (
      @(posedge link_clk) disable iff (!link_resetn)
      state == clkgen_pkg::ST_ACK && rd_mode && scl_fall
      |=> state == clkgen_pkg::ST_TX && oe_n == shreg[7]
      && shreg == $past(rd_byte) && ptr == $past(ptr) + 8'h01)
      else $error("read byte did not start with its top bit");

   // ********************************************************************
   // Register bus slave
   // ********************************************************************
   logic link_busy, busy_m, busy_s, tog_m, tog_s, tog_q, wr_event;
   logic [31:0] aw_q, next_aw_q, wd_q, next_wd_q, next_rdata;
   logic aw_got, next_aw_got, w_got, next_w_got, strb0, next_strb0;
   logic next_bvalid, next_rvalid, next_port_enable, wrote, next_wrote;
   logic [1:0] next_bresp, next_rresp;

   // Busy is registered on the link side first, so the crossing carries one
   // flip-flop output and never a glitching decode of the state bits.
   always_ff @(posedge link_clk) begin
      link_busy <= (state != clkgen_pkg::ST_IDLE);
   end

   always_ff @(posedge aclk) begin
      busy_m <= link_busy;
      busy_s <= busy_m;
      tog_m <= wr_tog;
      tog_s <= tog_m;
   end
   assign wr_event = tog_s ^ tog_q;

   // One write and one read may be outstanding; address and data may arrive
   // in either order and the answer waits for both.
   assign awready = ~aw_got & ~bvalid;
   assign wready = ~w_got & ~bvalid;
   assign arready = ~rvalid;

   always_comb begin
      next_aw_q = aw_q;
      next_wd_q = wd_q;
      next_strb0 = strb0;
      next_aw_got = aw_got;
      next_w_got = w_got;
      next_bvalid = bvalid;
      next_bresp = bresp;
      next_rvalid = rvalid;
      next_rresp = rresp;
      next_rdata = rdata;
      next_port_enable = port_enable;
      next_wrote = wrote;
      if (bvalid && bready) next_bvalid = 1'b0;
      if (rvalid && rready) next_rvalid = 1'b0;
      if (awvalid && awready) begin
         next_aw_got = 1'b1;
         next_aw_q = awaddr;
      end
      if (wvalid && wready) begin
         next_w_got = 1'b1;
         next_wd_q = wdata;
         next_strb0 = wstrb[0];
      end
      if (aw_got && w_got) begin
         next_aw_got = 1'b0;
         next_w_got = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = clkgen_pkg::RESP_OKAY;
         if (aw_q == clkgen_pkg::CTRL_ADDR) begin
            if (strb0) next_port_enable = wd_q[clkgen_pkg::EN_BIT];
         end else if (aw_q == clkgen_pkg::STATUS_ADDR) begin
            if (strb0 && wd_q[clkgen_pkg::WROTE_BIT]) next_wrote = 1'b0;
         end else begin
            next_bresp = clkgen_pkg::RESP_SLVERR;
         end
      end
      // A serial write landing with the clear keeps the flag set.
      if (wr_event) next_wrote = 1'b1;
      if (arvalid && arready) begin
         next_rvalid = 1'b1;
         next_rresp = clkgen_pkg::RESP_OKAY;
         next_rdata = 32'h0000_0000;
         if (araddr == clkgen_pkg::CTRL_ADDR) begin
            next_rdata[clkgen_pkg::EN_BIT] = port_enable;
         end else if (araddr == clkgen_pkg::STATUS_ADDR) begin
            next_rdata[clkgen_pkg::BUSY_BIT] = busy_s;
            next_rdata[clkgen_pkg::WROTE_BIT] = wrote;
         end else begin
            next_rresp = clkgen_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 32'h0000_0000;
         wd_q <= 32'h0000_0000;
         strb0 <= 1'b0;
         aw_got <= 1'b0;
         w_got <= 1'b0;
         bvalid <= 1'b0;
         bresp <= clkgen_pkg::RESP_OKAY;
         rvalid <= 1'b0;
         rresp <= clkgen_pkg::RESP_OKAY;
         rdata <= 32'h0000_0000;
         port_enable <= clkgen_pkg::EN_RESET;
         wrote <= 1'b0;
         tog_q <= 1'b0;
      end else begin
         aw_q <= next_aw_q;
         wd_q <= next_wd_q;
         strb0 <= next_strb0;
         aw_got <= next_aw_got;
         w_got <= next_w_got;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rresp <= next_rresp;
         rdata <= next_rdata;
         port_enable <= next_port_enable;
         wrote <= next_wrote;
         tog_q <= tog_s;
      end
   end

endmodule

// >>> dv/i2c_ctrl_model.sv
// Behavioural serial bus controller driving the configuration port.
`timescale 1ns/1ps
module i2c_ctrl_model #(
   parameter int Q = 40
) (
   input wire logic sda_wire,
   output logic scl,
   output logic sda_rel
);
   // ******************************************************************
   // Bus conditions and bit timing
   // ******************************************************************
   // The clock only moves inside frames; both lines rest high between.
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end

   // Also used as repeated start, entered with the clock low.
   task automatic start_c();
      sda_rel = 1'b1;
      #Q scl = 1'b1;
      #Q sda_rel = 1'b0;
      #Q scl = 1'b0;
      #Q;
   endtask

   task automatic stop_c();
      sda_rel = 1'b0;
      #Q scl = 1'b1;
      #Q sda_rel = 1'b1;
      #(2*Q);
   endtask

   // Data changes a quarter period after the fall, well inside low time.
   task automatic send_bit(input logic b);
      sda_rel = b;
      #Q scl = 1'b1;
      #(2*Q) scl = 1'b0;
      #Q;
   endtask

   task automatic recv_bit(output logic v);
      sda_rel = 1'b1;
      #Q scl = 1'b1;
      #Q v = sda_wire;
      #Q scl = 1'b0;
      #Q;
   endtask

   // Fewer than eight bits leaves a partial byte with no answer phase.
   task automatic write_bits(input logic [7:0] b, input int n,
                             output logic ack);
      logic v;
      ack = 1'b0;
      for (int i = 7; i > 7 - n; i--) send_bit(b[i]);
      if (n == 8) begin
         recv_bit(v);
         ack = !v;
      end
   endtask

   task automatic read_byte(output logic [7:0] b, input logic last);
      for (int i = 7; i >= 0; i--) recv_bit(b[i]);
      send_bit(last);
   endtask
endmodule

// >>> dv/test_clock_gen_config_i2c_slave.sv
// Self-checking bench of the clock generator configuration port.
`timescale 1ns/1ps
module test_clock_gen_config_i2c_slave;
   // ******************************************************************
   // Clocks, pins and instances
   // ******************************************************************
   logic aclk = 1'b0;
   logic link_clk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr = 32'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] araddr = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [1:0] frequency_set_select = 2'h0;
   logic awready, wready, bvalid, arready, rvalid, sda_oe_n, scl, sda_rel;
   logic sda_out;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   clkgen_pkg::clock_config_t active_config;
   wire logic sda_wire = sda_rel & (sda_oe_n | sda_out);
   int fails = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [7:0] mem [24];

   always #5 aclk = ~aclk;
   initial begin
      #1.7;
      forever #3 link_clk = ~link_clk;
   end

   clock_gen_config_i2c_slave clock_gen_config_i2c_slave_i (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .link_clk(link_clk), .scl_in(scl), .serial_data_pin_in(sda_wire),
      .serial_data_pin_out(sda_out), .serial_data_pin_oe_n(sda_oe_n),
      .frequency_set_select(frequency_set_select),
      .active_config(active_config));

   i2c_ctrl_model i2c_ctrl_model_i (
      .sda_wire(sda_wire), .scl(scl), .sda_rel(sda_rel));

   // ******************************************************************
   // Shared helpers
   // ******************************************************************
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails++;
         end_of_test();
      end
   end

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic settle();
      repeat (10) @(posedge aclk);
   endtask

   task automatic axi_wr(input logic [31:0] a, input logic [31:0] d,
                         output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   task automatic axi_rd(input logic [31:0] a, output logic [31:0] d,
                         output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   task automatic head(input logic [7:0] p);
      logic a;
      i2c_ctrl_model_i.start_c();
      i2c_ctrl_model_i.write_bits({clkgen_pkg::TARGET_ADDR, 1'b0}, 8, a);
      check(a, 1);
      i2c_ctrl_model_i.write_bits(p, 8, a);
      check(a, 1);
   endtask

   task automatic wr_regs(input logic [7:0] p, input logic [7:0] d[$]);
      logic a;
      head(p);
      foreach (d[i]) begin
         i2c_ctrl_model_i.write_bits(d[i], 8, a);
         check(a, 1);
         mem[p + i] = d[i];
      end
      i2c_ctrl_model_i.stop_c();
      settle();
   endtask

   task automatic rd_regs(input logic [7:0] p, input int n);
      logic a;
      logic [7:0] v;
      head(p);
      i2c_ctrl_model_i.start_c();
      i2c_ctrl_model_i.write_bits({clkgen_pkg::TARGET_ADDR, 1'b1}, 8, a);
      check(a, 1);
      for (int i = 0; i < n; i++) begin
         i2c_ctrl_model_i.read_byte(v, i == n - 1);
         check(v, mem[p + i]);
      end
      i2c_ctrl_model_i.stop_c();
   endtask

   task automatic cfg_check(input logic [1:0] s);
      clkgen_pkg::clock_config_t e;
      e.feedback_div = mem[clkgen_pkg::FB_BASE + s];
      e.output_div = mem[clkgen_pkg::OD_BASE + s];
      e.pll_mode = mem[clkgen_pkg::MODE_BASE + s];
      e.pll_skip_bit = mem[clkgen_pkg::MODE_BASE + s][clkgen_pkg::SKIP_BIT];
      e.output_drive_bit = mem[clkgen_pkg::OUT_BASE + s][3:0];
      e.output_style_bit = mem[clkgen_pkg::OUT_BASE + s][7:4];
      check(64'(active_config), 64'(e));
   endtask

   // ******************************************************************
   // Scenarios
   // ******************************************************************
   task automatic t_defaults();
      logic [31:0] d;
      logic [1:0] r;
      cfg_check(2'h0);
      axi_rd(clkgen_pkg::CTRL_ADDR, d, r);
      check(d[clkgen_pkg::EN_BIT], clkgen_pkg::EN_RESET);
      check(r, clkgen_pkg::RESP_OKAY);
   endtask

   task automatic t_write_out();
      logic [31:0] d;
      logic [1:0] r;
      wr_regs(8'h0C, {8'h5A, 8'hA3});
      cfg_check(2'h0);
      axi_rd(clkgen_pkg::STATUS_ADDR, d, r);
      check(d[clkgen_pkg::WROTE_BIT], 1);
      check(d[clkgen_pkg::BUSY_BIT], 0);
      axi_wr(clkgen_pkg::STATUS_ADDR, 32'h0000_0002, r);
      check(r, clkgen_pkg::RESP_OKAY);
      axi_rd(clkgen_pkg::STATUS_ADDR, d, r);
      check(d[clkgen_pkg::WROTE_BIT], 0);
   endtask

   task automatic t_select();
      wr_regs(8'h01, {8'h22});
      wr_regs(8'h09, {8'h81});
      for (int s = 0; s < 4; s++) begin
         @(posedge aclk);
         frequency_set_select <= 2'(s);
         settle();
         cfg_check(2'(s));
      end
      wr_regs(8'h0F, {8'hF0});
      cfg_check(2'h3);
   endtask

   task automatic t_refuse();
      logic a;
      logic [31:0] d;
      logic [1:0] r;
      i2c_ctrl_model_i.start_c();
      i2c_ctrl_model_i.write_bits(8'hDE, 8, a);
      check(a, 0);
      i2c_ctrl_model_i.stop_c();
      axi_wr(clkgen_pkg::CTRL_ADDR, 32'h0, r);
      i2c_ctrl_model_i.start_c();
      i2c_ctrl_model_i.write_bits({clkgen_pkg::TARGET_ADDR, 1'b0}, 8, a);
      check(a, 0);
      i2c_ctrl_model_i.stop_c();
      axi_wr(clkgen_pkg::CTRL_ADDR, 32'h1, r);
      check(r, clkgen_pkg::RESP_OKAY);
      axi_wr(32'h0000_0010, 32'h1, r);
      check(r, clkgen_pkg::RESP_SLVERR);
      axi_rd(32'h0000_0010, d, r);
      check(r, clkgen_pkg::RESP_SLVERR);
      check(d, 32'h0);
   endtask

   // A half byte before the stop must not disturb the whole byte before.
   task automatic t_partial();
      logic a;
      logic [31:0] d;
      logic [1:0] r;
      head(8'h10);
      // The serial clock rests low mid-frame while the bus looks at busy.
      axi_rd(clkgen_pkg::STATUS_ADDR, d, r);
      check(d[clkgen_pkg::BUSY_BIT], 1);
      i2c_ctrl_model_i.write_bits(8'h3C, 8, a);
      check(a, 1);
      mem[16] = 8'h3C;
      i2c_ctrl_model_i.write_bits(8'hFF, 4, a);
      i2c_ctrl_model_i.stop_c();
      settle();
      rd_regs(8'h10, 2);
   endtask

   initial begin
      for (int i = 0; i < 24; i++)
         mem[i] = i < 4 ? clkgen_pkg::FB_RESET :
                  i < 8 ? clkgen_pkg::OD_RESET :
                  i < 12 ? clkgen_pkg::MODE_RESET :
                  i < 16 ? clkgen_pkg::OUT_RESET : clkgen_pkg::SPARE_RESET;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (20) @(posedge aclk);
      t_defaults();
      t_write_out();
      t_select();
      t_refuse();
      t_partial();
      rd_regs(8'h0A, 6);
      rd_regs(8'h14, 4);
      end_of_test();
   end
endmodule
